// ==== tpio_top.sv ====
// three-port general-purpose i/o with peripheral override, slave port mode and ahb-lite registers
`timescale 1ns/1ps
module tpio_top
    import tpio_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // port c pins and peripheral override
    input wire logic [7:0] PC_IN,
    output logic [7:0] PC_OUT,
    output logic [7:0] PC_OE_N,
    input wire logic [7:0] PERIPH_SEL,
    input wire logic [7:0] PERIPH_OUT,
    input wire logic [7:0] PERIPH_OE,
    // port d pins
    input wire logic [7:0] PD_IN,
    output logic [7:0] PD_OUT,
    output logic [7:0] PD_OE_N,
    // port e pins
    input wire logic [2:0] PE_IN,
    output logic [2:0] PE_OUT,
    output logic [2:0] PE_OE_N,
    // status toward the analog front end and the system
    output logic [2:0] ANALOG_EN,
    output logic SLAVE_MODE
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] c_lat;
        logic [7:0] d_lat;
        logic [2:0] e_lat;
        logic [7:0] c_dir;
        logic [7:0] d_dir;
        logic slave_en;
        logic [2:0] e_dir;
        logic [2:0] acfg;
        logic [7:0] slv_in;
        logic wr_act;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [7:0] pc_out;
        logic [7:0] pc_oen;
        logic [7:0] pd_out;
        logic [7:0] pd_oen;
        logic [2:0] pe_out;
        logic [2:0] pe_oen;
        logic [2:0] analog_en;
    } tpio_state_t;

    localparam tpio_state_t ST_RESET = '{
        c_lat: RST_LATCH,
        d_lat: RST_LATCH,
        e_lat: RST_LATCH[2:0],
        c_dir: RST_C_DIR,
        d_dir: RST_D_DIR,
        slave_en: RST_E_CTL[SLAVE_EN_BIT],
        e_dir: RST_E_CTL[2:0],
        acfg: RST_ACFG,
        slv_in: 8'h00,
        wr_act: 1'b0,
        wr_pend: 1'b0,
        wr_idx: 8'h00,
        hrdata: 32'h00000000,
        hreadyout: 1'b1,
        pc_out: RST_LATCH,
        pc_oen: RST_C_DIR,
        pd_out: RST_LATCH,
        pd_oen: RST_D_DIR,
        pe_out: RST_LATCH[2:0],
        pe_oen: RST_E_CTL[2:0],
        analog_en: 3'h7
    };

    tpio_state_t s_q;
    tpio_state_t s_d;

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    tpio_pins_if #(.W(PIN_W)) pins ();

    assign pins.raw = {PE_IN, PD_IN, PC_IN};

    tpio_sync #(.W(PIN_W)) u_sync (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .pins(pins.syncer)
    );

    logic [7:0] pc_pin;
    logic [7:0] pd_pin;
    logic [2:0] pe_pin;

    // only synchronised levels are read below
    assign pc_pin = pins.sync[C_W-1:0];                // [R20]
    assign pd_pin = pins.sync[C_W+D_W-1:C_W];          // [R20]
    assign pe_pin = pins.sync[PIN_W-1:C_W+D_W];        // [R20]

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // analog use of the three port e pins follows the select field
    function automatic logic [2:0] analog_of(input logic [2:0] acfg);
        analog_of = (acfg == ACFG_ALL_DIGITAL) ? 3'h0 : 3'h7;
    endfunction : analog_of

    // register read value; used after any same-cycle write has landed
    function automatic logic [7:0] read_reg(input tpio_state_t s, input logic [7:0] idx,
                                            input logic [7:0] pc, input logic [7:0] pd,
                                            input logic [2:0] pe);
        case (idx)
            IDX_C_DATA: read_reg = pc;                                      // [R17]
            IDX_D_DATA: read_reg = s.slave_en ? s.slv_in : pd;              // [R17]
            IDX_E_DATA: read_reg = {5'h00, pe & ~analog_of(s.acfg)};        // [R13] [R19]
            IDX_C_DIR: read_reg = s.c_dir;
            IDX_D_DIR: read_reg = s.d_dir;
            IDX_E_CTL: read_reg = {3'h0, s.slave_en, 1'b0, s.e_dir};        // [R19]
            IDX_ACFG: read_reg = {5'h00, s.acfg};
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic addr_ok;
    logic take;
    logic [7:0] idx;
    logic wr_strobe;
    logic rd_strobe;

    assign addr_ok = (HADDR[31:IDX_MSB+1] == '0) && (HADDR[IDX_LSB-1:0] == 2'h0);
    assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign idx = HADDR[IDX_MSB:IDX_LSB];
    // strobes are active low and count only while chip select is low
    assign wr_strobe = s_q.slave_en && !pe_pin[E_CS_BIT] && !pe_pin[E_WR_BIT]; // [R8] [R11] [R12]
    assign rd_strobe = s_q.slave_en && !pe_pin[E_CS_BIT] && !pe_pin[E_RD_BIT]; // [R8] [R10] [R12]

    always_comb begin
        s_d = s_q;
        s_d.hreadyout = 1'b1;

        // data phase of a pending write: store the whole byte
        if (s_q.wr_pend) begin
            case (s_q.wr_idx)
                IDX_C_DATA: s_d.c_lat = HWDATA[7:0];          // [R17] [R18]
                IDX_D_DATA: s_d.d_lat = HWDATA[7:0];          // [R17] [R18]
                IDX_E_DATA: s_d.e_lat = HWDATA[2:0];          // [R17] [R18]
                IDX_C_DIR: s_d.c_dir = HWDATA[7:0];           // [R1]
                IDX_D_DIR: s_d.d_dir = HWDATA[7:0];           // [R5]
                IDX_E_CTL: begin
                    s_d.slave_en = HWDATA[SLAVE_EN_BIT];      // [R6]
                    s_d.e_dir = HWDATA[2:0];                  // [R7]
                end
                IDX_ACFG: s_d.acfg = HWDATA[2:0];
                default: s_d.acfg = s_q.acfg;
            endcase
        end

        // external master write latches the port d pins on first detection
        s_d.wr_act = wr_strobe;
        if (wr_strobe && !s_q.wr_act) begin
            s_d.slv_in = pd_pin;                              // [R11]
        end

        // address phase; read data taken from the updated state so a
        // write immediately before is seen by the following read
        s_d.wr_pend = take && HWRITE && addr_ok;
        s_d.wr_idx = idx;
        if (take && !HWRITE) begin
            s_d.hrdata = addr_ok ? {24'h000000, read_reg(s_d, idx, pc_pin, pd_pin, pe_pin)} : 32'h00000000;
        end

        // port c: peripheral owns data and enable only while selected
        for (int i = 0; i < C_W; i++) begin
            if (PERIPH_SEL[i]) begin
                s_d.pc_out[i] = PERIPH_OUT[i];                // [R3]
                s_d.pc_oen[i] = !PERIPH_OE[i];                // [R2] [R3]
            end else begin
                s_d.pc_out[i] = s_d.c_lat[i];
                s_d.pc_oen[i] = s_d.c_dir[i];                 // [R1]
            end
        end

        // port d: direction register ignored in slave mode
        if (s_d.slave_en) begin
            s_d.pd_out = s_d.d_lat;
            s_d.pd_oen = rd_strobe ? 8'h00 : 8'hFF;           // [R6] [R10]
        end else begin
            s_d.pd_out = s_d.d_lat;
            s_d.pd_oen = s_d.d_dir;                           // [R5]
        end

        // port e: direction keeps control even for analog pins
        s_d.pe_out = s_d.e_lat;
        s_d.pe_oen = s_d.e_dir;                               // [R7] [R14]
        s_d.analog_en = analog_of(s_d.acfg);                  // [R13]
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // power-on state leaves the port e pins analog
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q <= ST_RESET;                                  // [R16]
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------------
    assign HRDATA = s_q.hrdata;
    assign HREADYOUT = s_q.hreadyout;
    assign HRESP = 1'b0 & s_q.hreadyout;
    assign PC_OUT = s_q.pc_out;
    assign PC_OE_N = s_q.pc_oen;
    assign PD_OUT = s_q.pd_out;
    assign PD_OE_N = s_q.pd_oen;
    assign PE_OUT = s_q.pe_out;
    assign PE_OE_N = s_q.pe_oen;
    assign ANALOG_EN = s_q.analog_en;
    assign SLAVE_MODE = s_q.slave_en;
endmodule : tpio_top

// ==== tpio_pkg.sv ====
// constants, register map and rule summary for the three-port i/o block
// Operation
// R1: port c is eight pins, each pin's direction set by its own direction bit.
// R2: an enabled peripheral overrides a port c direction bit, forcing output or input.
// R3: select picks latch or peripheral data; peripheral enable acts only while selected.
// R4: software avoids read-modify-write on port c direction while overrides act.
// R5: port d is eight pins, directions set per pin while slave mode is off.
// R6: slave enable bit 4 of the port e control register makes port d a slave port.
// R7: port e has three pins whose directions are control register bits 2 to 0.
// R8: in slave mode the port e pins are read strobe, write strobe and chip select.
// R9: software sets port e pins as digital inputs before using slave mode.
// R10: read strobe low while selected reads the port d latch; high means no read.
// R11: write strobe low while selected writes the port d latch; high means no write.
// R12: chip select low selects the device; strobes only act while selected.
// R13: port e pins selected as analog inputs read back as zero.
// R14: port e direction bits keep driving the pin drivers even in analog use.
// R15: software keeps analog port e pins configured as inputs.
// R16: power-on reset sets all port e pins to analog inputs.
// R17: data register reads return pin levels; writes store to the output latch.
// R18: read-modify-write reads pins, modifies, and writes the whole byte to the latch.
// R19: unimplemented bits of port e data and control registers read as zero.
// R20: pin inputs pass a two-flop synchroniser before any read.
package tpio_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_C_DATA = 8'h07;
    localparam logic [7:0] IDX_D_DATA = 8'h08;
    localparam logic [7:0] IDX_E_DATA = 8'h09;
    localparam logic [7:0] IDX_C_DIR = 8'h87;
    localparam logic [7:0] IDX_D_DIR = 8'h88;
    localparam logic [7:0] IDX_E_CTL = 8'h89;
    localparam logic [7:0] IDX_ACFG = 8'h9F;
    // reset values
    localparam logic [7:0] RST_C_DIR = 8'hFF;
    localparam logic [7:0] RST_D_DIR = 8'hFF;
    localparam logic [7:0] RST_E_CTL = 8'h07;
    localparam logic [2:0] RST_ACFG = 3'h0;
    localparam logic [7:0] RST_LATCH = 8'h00;
    // field positions
    localparam int SLAVE_EN_BIT = 4;
    localparam int E_RD_BIT = 0;
    localparam int E_WR_BIT = 1;
    localparam int E_CS_BIT = 2;
    // analog select value that makes all port e pins digital
    localparam logic [2:0] ACFG_ALL_DIGITAL = 3'h7;
    // pin counts and the sync bus layout
    localparam int C_W = 8;
    localparam int D_W = 8;
    localparam int E_W = 3;
    localparam int PIN_W = C_W + D_W + E_W;
    // bus fields
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
endpackage : tpio_pkg

// ==== tpio_pins_if.sv ====
// interface carrying raw and synchronised pin levels between the top and its synchroniser
`timescale 1ns/1ps
interface tpio_pins_if #(parameter int W = 19);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport syncer (input raw, output sync);
    modport core (output raw, input sync);
endinterface : tpio_pins_if

// ==== tpio_sync.sv ====
// two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module tpio_sync #(
    parameter int W = 19
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    tpio_pins_if.syncer pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tpio_sync_st_t;

    tpio_sync_st_t st_q;
    tpio_sync_st_t st_d;

    generate
        if (W < 1) begin : g_chk
            $error("tpio_sync width must be at least one");
        end
    endgenerate

    // first stage only feeds the second; nothing else looks at it
    always_comb begin
        st_d = st_q;
        st_d.s1 = pins.raw; // [R20]
        st_d.s2 = st_q.s1;  // [R20]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign pins.sync = st_q.s2;
endmodule : tpio_sync

// ==== tpio_monitor.sv ====
// checker for the three-port i/o top ports
`timescale 1ns/1ps
module tpio_monitor
    import tpio_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [7:0] PC_OUT,
    input wire logic [7:0] PC_OE_N,
    input wire logic [7:0] PERIPH_SEL,
    input wire logic [7:0] PERIPH_OUT,
    input wire logic [7:0] PERIPH_OE,
    input wire logic [7:0] PD_OE_N,
    input wire logic [2:0] PE_IN,
    input wire logic [2:0] PE_OE_N,
    input wire logic [2:0] ANALOG_EN,
    input wire logic SLAVE_MODE
);
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic e_wr;
    // a taken write to the port e control word
    assign e_wr = HSEL && HREADYOUT && CE && HTRANS == HTRANS_NONSEQ && HWRITE && HADDR == {22'h0, IDX_E_CTL, 2'h0};
    bus_ok_a: assert property (HREADYOUT && !HRESP && HRDATA[31:8] == 24'h0)
        else $error("bus answer or upper read bits wrong");
    rst_state_a: assert property (!$past(ARST_N) |-> ANALOG_EN == 3'h7 && !SLAVE_MODE && PE_OE_N == 3'h7)
        else $error("state after reset wrong");
    per_data_a: assert property ($past(ARST_N) && $past(CE) |->
        ((PC_OUT ^ $past(PERIPH_OUT)) & $past(PERIPH_SEL)) == 8'h00) else $error("peripheral data not on pin");
    per_oe_a: assert property ($past(ARST_N) && $past(CE) |->
        ((~PC_OE_N ^ $past(PERIPH_OE)) & $past(PERIPH_SEL)) == 8'h00) else $error("peripheral enable wrong");
    e_ctl_a: assert property ($changed(PE_OE_N) || $changed(SLAVE_MODE) |-> $past(e_wr, 2))
        else $error("port e control changed without a write");
    s_read_a: assert property ((SLAVE_MODE && !PE_IN[2] && !PE_IN[0])[*4] |-> PD_OE_N == 8'h00)
        else $error("slave read not driving");
    s_nosel_a: assert property ((SLAVE_MODE && PE_IN[2])[*4] |-> PD_OE_N == 8'hFF)
        else $error("slave drives while deselected");
    s_nord_a: assert property ((SLAVE_MODE && PE_IN[0])[*4] |-> PD_OE_N == 8'hFF)
        else $error("slave drives without read strobe");
endmodule : tpio_monitor
bind tpio_top tpio_monitor u_mon (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PC_OUT(PC_OUT),
    .PC_OE_N(PC_OE_N), .PERIPH_SEL(PERIPH_SEL), .PERIPH_OUT(PERIPH_OUT), .PERIPH_OE(PERIPH_OE), .PD_OE_N(PD_OE_N),
    .PE_IN(PE_IN), .PE_OE_N(PE_OE_N), .ANALOG_EN(ANALOG_EN), .SLAVE_MODE(SLAVE_MODE));

// ==== tpio_board.sv ====
// board model: each pin level from the block's driver or the outside source
`timescale 1ns/1ps
module tpio_board (
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe_n,
    input wire logic [7:0] c_ext,
    output logic [7:0] c_pin,
    input wire logic [7:0] d_out,
    input wire logic [7:0] d_oe_n,
    input wire logic [7:0] d_ext,
    output logic [7:0] d_pin,
    input wire logic [2:0] e_out,
    input wire logic [2:0] e_oe_n,
    input wire logic [2:0] e_ext,
    output logic [2:0] e_pin
);
    // driven pins show the block, released pins the outside world; no contention modelled
    assign c_pin = (c_out & ~c_oe_n) | (c_ext & c_oe_n);
    assign d_pin = (d_out & ~d_oe_n) | (d_ext & d_oe_n);
    assign e_pin = (e_out & ~e_oe_n) | (e_ext & e_oe_n);
endmodule : tpio_board

// ==== tpio_tb.sv ====
// self-checking bench for the three-port i/o block
`timescale 1ns/1ps
module tb;
    import tpio_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, slave_mode, dph = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, pe_in, pe_out, pe_oe_n, pe_ext = 3'h7, analog_en;
    logic [7:0] pc_in, pc_out, pc_oe_n, psel = 8'h00, pout = 8'h00, poe = 8'h00, pd_in, pd_out, pd_oe_n, r, v;
    logic [7:0] c_ext = 8'h00, d_ext = 8'h00;
    logic [31:0] expq[$];
    int err_count = 0, check_count = 0, seed = 32'hc817;
    // ----------------
    // harness
    // ----------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    tpio_top dut (.CORE_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE_N(pc_oe_n), .PERIPH_SEL(psel), .PERIPH_OUT(pout),
        .PERIPH_OE(poe), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE_N(pd_oe_n), .PE_IN(pe_in), .PE_OUT(pe_out),
        .PE_OE_N(pe_oe_n), .ANALOG_EN(analog_en), .SLAVE_MODE(slave_mode));
    tpio_board u_brd (.c_out(pc_out), .c_oe_n(pc_oe_n), .c_ext(c_ext), .c_pin(pc_in), .d_out(pd_out),
        .d_oe_n(pd_oe_n), .d_ext(d_ext), .d_pin(pd_in), .e_out(pe_out), .e_oe_n(pe_oe_n), .e_ext(pe_ext), .e_pin(pe_in));
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ad
    task automatic chk(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic pin(input logic [7:0] got, exp, input string what);
        chk({24'h0, got}, {24'h0, exp}, what);
    endtask : pin
    // one single transfer; waits for ready rather than assuming zero wait states
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        expq.push_back({24'h0, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    // read data is taken at the end of the data phase and matched against the oldest note
    always @(posedge clk) begin
        if (dph && hready) begin
            chk(hrdata, expq.pop_front(), "read");
        end
        dph <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hready;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        test_done;
    end
    // ----------------
    // scenarios
    // ----------------
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(ad(IDX_C_DIR), 8'hFF);
        rd(ad(IDX_D_DIR), 8'hFF);
        rd(ad(IDX_E_CTL), 8'h07);
        rd(ad(IDX_ACFG), 8'h00);
        rd(32'h0000_03FC, 8'h00);
        $display("reset test done");
        c_ext <= 8'($random(seed));
        r = 8'($random(seed));
        wr(ad(IDX_C_DATA), r);
        wr(ad(IDX_C_DIR), 8'h0F); // whole-byte write, never read-modify-write
        repeat (4) @(posedge clk);
        pin(pc_oe_n, 8'h0F, "c dir");
        v = (r & 8'hF0) | (c_ext & 8'h0F);
        rd(ad(IDX_C_DATA), v);
        wr(ad(IDX_C_DATA), v | 8'h01); // inputs' latches take the pin levels
        wr(ad(IDX_C_DIR), 8'h00);
        repeat (2) @(posedge clk);
        pin(pc_out, v | 8'h01, "rmw latch");
        psel <= 8'hF0;
        pout <= 8'($random(seed));
        poe <= 8'hC0;
        repeat (2) @(posedge clk);
        pin(pc_out & 8'hF0, pout & 8'hF0, "periph data");
        pin(pc_oe_n, 8'h30, "periph oe");
        rd(ad(IDX_C_DIR), 8'h00);
        psel <= 8'h00;
        $display("port c test done");
        d_ext <= 8'($random(seed));
        wr(ad(IDX_D_DATA), 8'hA5);
        wr(ad(IDX_D_DIR), 8'hF0);
        repeat (4) @(posedge clk);
        pin(pd_oe_n, 8'hF0, "d dir");
        rd(ad(IDX_D_DATA), 8'h05 | (d_ext & 8'hF0));
        $display("port d test done");
        pe_ext <= 3'h5;
        wr(ad(IDX_E_CTL), 8'h00); // drivers on while analog, against the usual software care
        repeat (4) @(posedge clk);
        pin({5'h0, pe_oe_n}, 8'h00, "e dir analog");
        rd(ad(IDX_E_DATA), 8'h00);
        wr(ad(IDX_E_CTL), 8'h06);
        wr(ad(IDX_ACFG), {5'h0, ACFG_ALL_DIGITAL});
        repeat (4) @(posedge clk);
        rd(ad(IDX_E_DATA), 8'h04);
        $display("port e test done");
        pe_ext <= 3'h7;
        wr(ad(IDX_E_CTL), 8'hFF); // pins already digital; made inputs in the same write that sets slave enable
        rd(ad(IDX_E_CTL), 8'h17);
        pin({7'h0, slave_mode}, 8'h01, "slave on");
        d_ext <= 8'h3C;
        pe_ext <= 3'h1;
        repeat (4) @(posedge clk);
        pe_ext <= 3'h7;
        rd(ad(IDX_D_DATA), 8'h3C);
        d_ext <= 8'h99;
        pe_ext <= 3'h5;
        repeat (4) @(posedge clk);
        rd(ad(IDX_D_DATA), 8'h3C);
        pe_ext <= 3'h2;
        repeat (4) @(posedge clk);
        pin(pd_oe_n, 8'h00, "slave read oe");
        pin(pd_out, 8'hA5, "slave read data");
        pe_ext <= 3'h6;
        repeat (4) @(posedge clk);
        pin(pd_oe_n, 8'hFF, "deselected");
        $display("slave test done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(ad(IDX_E_CTL), 8'h07);
        pin({5'h0, analog_en}, 8'h07, "analog after reset");
        $display("second reset test done");
        test_done;
    end
endmodule : tb
